// File: verilog/dmr_defs.vh
// Constants for the I/O configuration and thermal/repair mode registers.
// Assumes an 8-bit mode register data path and a 6-bit register address.
`ifndef DMR_DEFS_VH
`define DMR_DEFS_VH
`define DMR_ADDR_W 6
`define DMR_IO_CFG_ADDR 6'h03
`define DMR_THERM_ADDR 6'h04
`define DMR_IO_PUCAL_BIT 0
`define DMR_IO_WPST_BIT 1
`define DMR_IO_PROT_BIT 2
`define DMR_IO_PULLDOWN_DRIVE_STRENGTH_LSB 3
`define DMR_IO_PULLDOWN_DRIVE_STRENGTH_MSB 5
`define DMR_IO_RDBI_BIT 6
`define DMR_IO_WDBI_BIT 7
`define DMR_TH_RATE_LSB 0
`define DMR_TH_RATE_MSB 2
`define DMR_TH_SRA_BIT 3
`define DMR_TH_RPR_BIT 4
`define DMR_TH_OFS_LSB 5
`define DMR_TH_OFS_MSB 6
`define DMR_TH_TUF_BIT 7
`define DMR_RST_PUCAL 1'h1
`define DMR_RST_WPST 1'h0
`define DMR_RST_PROT 1'h0
`define DMR_RST_PULLDOWN_DRIVE_STRENGTH 3'h6
`define DMR_RST_DBI 1'h0
`define DMR_RST_RATE 3'h3
`define DMR_RST_OFS 2'h0
`define DMR_RST_SRA 1'h0
`define DMR_RST_RPR 1'h0
`define DMR_PULLDOWN_DRIVE_STRENGTH_RFU 3'h0
`define DMR_PULLDOWN_DRIVE_STRENGTH_RSV 3'h7
`define DMR_OFS_RSV 2'h3
`define DMR_RATE_DERATE 3'h6
`endif

// File: verilog/dmr_set_point_pair.v
// Two set-point copies of one field: writes and reads go to the copy writeSel picks, operation uses the one operSel picks.
// Assumes write strobe and selects synchronous to sys_clk.
`default_nettype none
`include "dmr_defs.vh"
module dmr_set_point_pair #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] RESET_VALUE = {WIDTH{1'b0}}
) (
  // Clock and reset
  input wire sys_clk,
  input wire rst,
  // Access side
  input wire writeEn,
  input wire writeSel,
  input wire operSel,
  input wire [WIDTH-1:0] writeData,
  // Values
  output wire [WIDTH-1:0] accessValue,
  output wire [WIDTH-1:0] operValue
);
  // Each copy is its own register, so no storage has two processes driving it.
  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1) begin : gCopy
      reg [WIDTH-1:0] copyVal;
      always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          copyVal <= RESET_VALUE;
        end else if (writeEn && (writeSel ^ (i == 0))) begin
          copyVal <= writeData;
        end
      end
    end
  endgenerate
  assign accessValue = writeSel ? gCopy[1].copyVal : gCopy[0].copyVal;
  assign operValue = operSel ? gCopy[1].copyVal : gCopy[0].copyVal;
endmodule // dmr_set_point_pair
`default_nettype wire

// File: verilog/dmr_rate_tracker.v
// Holds the reported refresh-rate code and the flag that marks a change since the last read.
// Assumes the rate code from the sensor is synchronous and settles after initialisation.
`default_nettype none
`include "dmr_defs.vh"
module dmr_rate_tracker (
  // Clock and reset
  input wire sys_clk,
  input wire rst,
  // Sensor side
  input wire initDone,
  input wire [2:0] sensorRate,
  input wire derateNeeded,
  // Reader side
  input wire readStrobe,
  // State
  output reg [2:0] rateCode,
  output reg tempUpdateFlag
);
  reg [2:0] next_rateCode;
  always @* begin
    next_rateCode = sensorRate;
    if (derateNeeded) begin
      next_rateCode = `DMR_RATE_DERATE;
    end
  end
  // Before initialisation the default code is held, since the sensor is not yet valid.
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rateCode <= `DMR_RST_RATE;
      tempUpdateFlag <= 1'b0;
    end else begin
      if (initDone) begin
        rateCode <= next_rateCode;
      end
      // A change in the same cycle as a read keeps the flag set.
      if (initDone && next_rateCode != rateCode) begin
        tempUpdateFlag <= 1'b1;
      end else if (readStrobe) begin
        tempUpdateFlag <= 1'b0;
      end
    end
  end
endmodule // dmr_rate_tracker
`default_nettype wire

// File: verilog/dmr_io_thermal_regs.v
// I/O configuration and thermal/repair mode registers of the DRAM.
// Assumes decoded mode register write/read commands, one cycle each, on sys_clk.
`default_nettype none
`include "dmr_defs.vh"
module dmr_io_thermal_regs (
  // Clock and reset
  input wire sys_clk,
  input wire rst,
  // Mode register command port
  input wire modeRegWriteCmd,
  input wire modeRegReadCmd,
  input wire [`DMR_ADDR_W-1:0] regAddr,
  input wire [7:0] writeData,
  output reg [7:0] readData,
  output reg readValid,
  // Set-point selects
  input wire writeSetPointSelect,
  input wire operatingSetPointSelect,
  // Thermal sensor
  input wire initDone,
  input wire [2:0] sensorRate,
  input wire derateNeeded,
  // Operating values
  output wire pullupCalPoint,
  output wire writePostambleLen,
  output wire [2:0] pulldownDriveStrength,
  output wire readBusInversionEn,
  output wire writeBusInversionEn,
  output wire repairProtect,
  output wire repairModeEntry,
  output wire selfRefreshAbort,
  output wire [1:0] thermalOffset,
  output wire [2:0] refreshRate,
  output wire tempUpdateFlag,
  output wire tempAbove85,
  output wire driveStrengthInvalid,
  output wire thermalOffsetInvalid,
  output wire repairEntryRefused
);
  localparam ST_IDLE = 2'b01;
  localparam ST_READ = 2'b10;
  reg [1:0] state;
  reg pucal;
  reg protect;
  reg repairMode;
  reg srAbort;
  reg [1:0] offset;
  reg refused;
  wire ioWrite;
  wire thWrite;
  wire thRead;
  wire [5:0] spAccess;
  wire [5:0] spOper;
  wire [5:0] spWriteData;
  wire [2:0] rateCode;
  reg [7:0] next_readData;

  assign ioWrite = modeRegWriteCmd && (regAddr == `DMR_IO_CFG_ADDR);
  assign thWrite = modeRegWriteCmd && (regAddr == `DMR_THERM_ADDR);
  assign thRead = modeRegReadCmd && (regAddr == `DMR_THERM_ADDR);
  assign spWriteData = {writeData[`DMR_IO_WDBI_BIT], writeData[`DMR_IO_RDBI_BIT],
    writeData[`DMR_IO_PULLDOWN_DRIVE_STRENGTH_MSB:`DMR_IO_PULLDOWN_DRIVE_STRENGTH_LSB], writeData[`DMR_IO_WPST_BIT]};

  // Postamble, drive strength and inversion enables live in two set points.
  dmr_set_point_pair #(
    .WIDTH(6),
    .RESET_VALUE({`DMR_RST_DBI, `DMR_RST_DBI, `DMR_RST_PULLDOWN_DRIVE_STRENGTH, `DMR_RST_WPST})
  ) uSetPoints (
    .sys_clk(sys_clk),
    .rst(rst),
    .writeEn(ioWrite),
    .writeSel(writeSetPointSelect),
    .operSel(operatingSetPointSelect),
    .writeData(spWriteData),
    .accessValue(spAccess),
    .operValue(spOper)
  );

  dmr_rate_tracker uRate (
    .sys_clk(sys_clk),
    .rst(rst),
    .initDone(initDone),
    .sensorRate(sensorRate),
    .derateNeeded(derateNeeded),
    .readStrobe(thRead),
    .rateCode(rateCode),
    .tempUpdateFlag(tempUpdateFlag)
  );

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pucal <= `DMR_RST_PUCAL;
      protect <= `DMR_RST_PROT;
      repairMode <= `DMR_RST_RPR;
      srAbort <= `DMR_RST_SRA;
      offset <= `DMR_RST_OFS;
      refused <= 1'b0;
    end else begin
      refused <= 1'b0;
      if (ioWrite) begin
        pucal <= writeData[`DMR_IO_PUCAL_BIT];
        // Only a power-on reset can clear protection, so a written zero is dropped.
        if (writeData[`DMR_IO_PROT_BIT]) begin
          protect <= 1'b1;
        end
      end
      if (thWrite) begin
        srAbort <= writeData[`DMR_TH_SRA_BIT];
        offset <= writeData[`DMR_TH_OFS_MSB:`DMR_TH_OFS_LSB];
        if (writeData[`DMR_TH_RPR_BIT] && protect) begin
          refused <= 1'b1;
        end else begin
          repairMode <= writeData[`DMR_TH_RPR_BIT];
        end
      end
    end
  end

  // Reads answer one cycle after the command; the thermal and I/O configuration registers return data, other addresses zero.
  always @* begin
    next_readData = 8'h00;
    if (regAddr == `DMR_THERM_ADDR) begin
      next_readData[`DMR_TH_RATE_MSB:`DMR_TH_RATE_LSB] = rateCode;
      next_readData[`DMR_TH_SRA_BIT] = srAbort;
      next_readData[`DMR_TH_RPR_BIT] = repairMode;
      next_readData[`DMR_TH_OFS_MSB:`DMR_TH_OFS_LSB] = offset;
      next_readData[`DMR_TH_TUF_BIT] = tempUpdateFlag;
    end else if (regAddr == `DMR_IO_CFG_ADDR) begin
      // The register is write-only; the access copy is still shown for debug.
      next_readData[`DMR_IO_PUCAL_BIT] = pucal;
      next_readData[`DMR_IO_WPST_BIT] = spAccess[0];
      next_readData[`DMR_IO_PROT_BIT] = protect;
      next_readData[`DMR_IO_PULLDOWN_DRIVE_STRENGTH_MSB:`DMR_IO_PULLDOWN_DRIVE_STRENGTH_LSB] = spAccess[3:1];
      next_readData[`DMR_IO_RDBI_BIT] = spAccess[4];
      next_readData[`DMR_IO_WDBI_BIT] = spAccess[5];
    end
  end

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state <= ST_IDLE;
      readData <= 8'h00;
      readValid <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          readValid <= 1'b0;
          if (modeRegReadCmd) begin
            readData <= next_readData;
            readValid <= 1'b1;
            state <= ST_READ;
          end
        end
        ST_READ: begin
          if (modeRegReadCmd) begin
            readData <= next_readData;
            readValid <= 1'b1;
          end else begin
            readValid <= 1'b0;
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
          readValid <= 1'b0;
        end
      endcase
    end
  end

  assign pullupCalPoint = pucal;
  assign writePostambleLen = spOper[0];
  assign pulldownDriveStrength = spOper[3:1];
  assign readBusInversionEn = spOper[4];
  assign writeBusInversionEn = spOper[5];
  assign repairProtect = protect;
  assign repairModeEntry = repairMode;
  assign selfRefreshAbort = srAbort;
  assign thermalOffset = offset;
  assign refreshRate = rateCode;
  assign tempAbove85 = rateCode[`DMR_TH_RATE_MSB];
  assign driveStrengthInvalid = (spOper[3:1] == `DMR_PULLDOWN_DRIVE_STRENGTH_RFU) || (spOper[3:1] == `DMR_PULLDOWN_DRIVE_STRENGTH_RSV);
  assign thermalOffsetInvalid = (offset == `DMR_OFS_RSV);
  assign repairEntryRefused = refused;
endmodule // dmr_io_thermal_regs
`default_nettype wire

// File: sim/dmr_regs_sva.sv
// Checker for the I/O configuration and thermal/repair register ports.
// Assumes one clock domain and the top module's port names.
`default_nettype none
module dmr_regs_sva (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Command side
  input wire logic modeRegWriteCmd,
  input wire logic modeRegReadCmd,
  input wire logic [5:0] regAddr,
  input wire logic [7:0] writeData,
  // Sensor side
  input wire logic initDone,
  input wire logic derateNeeded,
  // State
  input wire logic repairProtect,
  input wire logic repairModeEntry,
  input wire logic repairEntryRefused,
  input wire logic [1:0] thermalOffset,
  input wire logic [2:0] refreshRate,
  input wire logic [2:0] pulldownDriveStrength,
  input wire logic tempUpdateFlag,
  input wire logic tempAbove85,
  input wire logic driveStrengthInvalid,
  input wire logic thermalOffsetInvalid
);
  logic [7:0] wdPast;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Write data is compared a cycle late, so keep a copy.
  always_ff @(posedge sys_clk) wdPast <= writeData;
  sequence s_thWr; modeRegWriteCmd && regAddr == 6'h04; endsequence
  sequence s_thRd; modeRegReadCmd && regAddr == 6'h04; endsequence
  property p_sticky; repairProtect |=> repairProtect; endproperty
  a_sticky: assert property (p_sticky) else $error("protect bit dropped");
  property p_refuse;
    s_thWr ##0 (repairProtect && writeData[4]) |=> repairEntryRefused && repairModeEntry == $past(repairModeEntry);
  endproperty
  a_refuse: assert property (p_refuse) else $error("entry not refused");
  property p_tufClr; s_thRd ##1 $stable(refreshRate) |-> !tempUpdateFlag; endproperty
  a_tufClr: assert property (p_tufClr) else $error("flag not cleared");
  property p_tufSet; !$stable(refreshRate) |-> tempUpdateFlag; endproperty
  a_tufSet: assert property (p_tufSet) else $error("flag not set");
  property p_hot; tempAbove85 == refreshRate[2]; endproperty
  a_hot: assert property (p_hot) else $error("hot flag wrong");
  property p_pulldown_drive_strength;
    driveStrengthInvalid == (pulldownDriveStrength == 3'h0 || pulldownDriveStrength == 3'h7);
  endproperty
  a_pulldown_drive_strength: assert property (p_pulldown_drive_strength) else $error("drive flag wrong");
  property p_ofs; thermalOffsetInvalid == (thermalOffset == 2'h3); endproperty
  a_ofs: assert property (p_ofs) else $error("offset flag wrong");
  property p_derate; initDone && derateNeeded |=> refreshRate == 3'h6; endproperty
  a_derate: assert property (p_derate) else $error("derate code wrong");
  property p_ofsWr; s_thWr |=> thermalOffset == wdPast[6:5]; endproperty
  a_ofsWr: assert property (p_ofsWr) else $error("offset not written");
endmodule // dmr_regs_sva
bind dmr_io_thermal_regs dmr_regs_sva u_sva (.*);
`default_nettype wire

// File: sim/dmr_ctrl_model.sv
// Memory controller model issuing mode register writes and reads.
// Assumes its task is called from the bench right after a rising edge.
`default_nettype none
module dmr_ctrl_model #(
  parameter bit FAST_CLK = 1'b1
) (
  // Clock
  input wire logic sys_clk,
  // Command bus
  output var logic modeRegWriteCmd,
  output var logic modeRegReadCmd,
  output var logic [5:0] regAddr,
  output var logic [7:0] writeData
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    modeRegWriteCmd = 1'b0;
    modeRegReadCmd = 1'b0;
    regAddr = 6'h00;
    writeData = 8'h00;
  end
  // One sampling edge per command; the idle cycle after it keeps drivers apart.
  task automatic issue(input logic w, input logic [5:0] a, input logic [7:0] d);
    logic [7:0] v;
    // Thermal writes go out with the self-refresh abort bit cleared; I/O writes clear the postamble bit when FAST_CLK is low.
    v = d;
    if (a == 6'h04) v[3] = 1'b0;
    if (a == 6'h03 && !FAST_CLK) v[1] = 1'b0;
    @(posedge sys_clk);
    modeRegWriteCmd <= w;
    modeRegReadCmd <= !w;
    regAddr <= a;
    writeData <= v;
    @(posedge sys_clk);
    modeRegWriteCmd <= 1'b0;
    modeRegReadCmd <= 1'b0;
    regAddr <= ~a;
    writeData <= ~v;
  endtask
endmodule // dmr_ctrl_model
`default_nettype wire

// File: sim/testbench.sv
// Self-checking bench for the I/O configuration and thermal/repair registers.
// Assumes the controller model owns the command bus and the bench the rest.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0, rst = 1'b1, writeSetPointSelect = 1'b0, operatingSetPointSelect = 1'b0;
  logic initDone = 1'b0, derateNeeded = 1'b0, modeRegWriteCmd, modeRegReadCmd, readValid;
  logic [2:0] sensorRate = 3'h5;
  logic [5:0] regAddr;
  logic [7:0] writeData, readData;
  logic pullupCalPoint, writePostambleLen, readBusInversionEn, writeBusInversionEn, repairProtect;
  logic repairModeEntry, selfRefreshAbort, tempUpdateFlag, tempAbove85, repairEntryRefused;
  logic driveStrengthInvalid, thermalOffsetInvalid;
  logic [2:0] pulldownDriveStrength, refreshRate;
  logic [1:0] thermalOffset;
  int fail_count = 0, n_tests = 0;
  logic [15:0] rows [5] = '{{2'b00, 8'hd9, 6'h36}, {2'b10, 8'h42, 6'h36}, {2'b11, 8'h42, 6'h11},
    {2'b01, 8'h38, 6'h11}, {2'b00, 8'h38, 6'h0e}};
  always #12.5 sys_clk = ~sys_clk;
  dmr_ctrl_model ctl (.*);
  dmr_io_thermal_regs dut (.*);
  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wrap_up;
    $display("checks %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task wr(input logic [5:0] a, input logic [7:0] d);
    ctl.issue(1'b1, a, d);
    #1;
  endtask
  task rd(input logic [5:0] a, input logic [7:0] exp);
    ctl.issue(1'b0, a, 8'h00);
    #1;
    chk({7'h00, readValid}, 8'h01);
    chk(readData, exp);
  endtask
  // The sensor path has no fixed latency, so poll it under a bound.
  task waitRate(input logic [2:0] exp);
    int i;
    for (i = 0; i < 20 && refreshRate !== exp; i++) begin
      @(posedge sys_clk);
      #1;
    end
    if (refreshRate !== exp) begin
      fail_count++;
      $display("ERROR at %0t: refresh rate did not reach %h", $time, exp);
      wrap_up();
    end
  endtask
  initial begin
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    #1;
    chk({pullupCalPoint, writePostambleLen, pulldownDriveStrength, readBusInversionEn, writeBusInversionEn,
      repairProtect}, 8'hb0);
    chk({refreshRate, tempUpdateFlag, repairModeEntry, selfRefreshAbort, thermalOffset}, 8'h60);
    @(posedge sys_clk);
    operatingSetPointSelect <= 1'b1;
    repeat (2) @(posedge sys_clk);
    #1;
    chk({5'h00, pulldownDriveStrength}, 8'h06);
    foreach (rows[i]) begin
      @(posedge sys_clk);
      writeSetPointSelect <= rows[i][15];
      operatingSetPointSelect <= rows[i][14];
      wr(6'h03, rows[i][13:6]);
      @(posedge sys_clk);
      #1;
      chk({2'b00, writeBusInversionEn, readBusInversionEn, pulldownDriveStrength, writePostambleLen},
        {2'b00, rows[i][5:0]});
      chk({7'h00, pullupCalPoint}, {7'h00, rows[i][6]});
    end
    rd(6'h03, 8'h38);
    @(posedge sys_clk);
    writeSetPointSelect <= 1'b1;
    rd(6'h03, 8'h42);
    rd(6'h3f, 8'h00);
    @(posedge sys_clk);
    initDone <= 1'b1;
    waitRate(3'h5);
    chk({7'h00, tempUpdateFlag}, 8'h01);
    rd(6'h04, 8'h85);
    chk({7'h00, tempUpdateFlag}, 8'h00);
    wr(6'h04, 8'hff);
    chk({refreshRate, tempUpdateFlag, repairModeEntry, selfRefreshAbort, thermalOffset}, 8'hab);
    wr(6'h04, 8'h20);
    chk({refreshRate, tempUpdateFlag, repairModeEntry, selfRefreshAbort, thermalOffset}, 8'ha1);
    @(posedge sys_clk);
    derateNeeded <= 1'b1;
    waitRate(3'h6);
    chk({6'h00, tempAbove85, tempUpdateFlag}, 8'h03);
    wr(6'h03, 8'h04);
    chk({7'h00, repairProtect}, 8'h01);
    wr(6'h03, 8'h00);
    chk({7'h00, repairProtect}, 8'h01);
    wr(6'h04, 8'h10);
    chk({6'h00, repairEntryRefused, repairModeEntry}, 8'h02);
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    operatingSetPointSelect <= 1'b0;
    @(posedge sys_clk);
    #1;
    chk({4'h0, repairProtect, pulldownDriveStrength}, 8'h06);
    wrap_up();
  end
endmodule // testbench
`default_nettype wire
